// File: bsl_consts.svh
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH

// link mode selection bytes
`define BSL_MODE_ASYNC   8'h86
`define BSL_MODE_SYNC    8'h30

// command codes
`define BSL_CMD_RAM      8'h10
`define BSL_CMD_FSUM     8'h20
`define BSL_CMD_INFO     8'h30

// acknowledge codes
`define BSL_ACK_OK       8'h10
`define BSL_ACK_BAD      8'h11
`define BSL_ACK_RXERR    8'h18
`define BSL_NIB_RXERR    4'h8
`define BSL_NIB_BADCMD   4'h1
`define BSL_PREV_HI_RST  4'h0

// segment layout
`define BSL_PW_BYTES     12
`define BSL_PW_ERASED    8'hFF
`define BSL_PW_LAST      4'hC
`define BSL_HDR_ADDR_END 4'h4
`define BSL_HDR_LAST     4'h6

// flash size walked by the sum command, in bytes
`define BSL_FLASH_BYTES  32'h0004_0000

`endif

// File: bsl_flash_sum.sv
`timescale 1ns/1ps
`include "bsl_consts.svh"
module bsl_flash_sum
    import bsl_pkg::*;
#(
    parameter logic [31:0] FLASH_BYTES = `BSL_FLASH_BYTES
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic [7:0]  flash_rdata,
    output logic [31:0]      flash_addr,
    output logic [15:0]      sum,
    output logic             done
);
    bsl_fsum_t fs_reg;
    bsl_fsum_t fs_next;

    // flash answers one cycle after the address; pend marks that cycle
    always_comb begin
        fs_next      = fs_reg;
        fs_next.pend = fs_reg.run;
        if (fs_reg.pend) begin
            fs_next.sum = 16'(fs_reg.sum + {8'h00, flash_rdata});
        end
        if (fs_reg.run) begin
            if (fs_reg.addr == 32'(FLASH_BYTES - 32'h1)) begin
                fs_next.run = 1'b0;
            end else begin
                fs_next.addr = fs_reg.addr + 32'h1;
            end
        end
        // done holds until the next start: a slow echo take cannot miss it
        if (fs_reg.pend && !fs_reg.run) begin
            fs_next.done = 1'b1;
        end
        if (start && !fs_reg.run && !fs_reg.pend) begin
            fs_next.done = 1'b0;
            fs_next.run  = 1'b1;
            fs_next.addr = 32'h0;
            fs_next.sum  = 16'h0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fs_reg <= '0;
        end else begin
            fs_reg <= fs_next;
        end
    end

    assign flash_addr = fs_reg.addr;
    assign sum        = fs_reg.sum;
    assign done       = fs_reg.done;
endmodule : bsl_flash_sum

// File: bsl_host_model.sv
`timescale 1ns/1ps
module bsl_host_model (
    input  wire logic       core_clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_error,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    logic [7:0] got;
    logic       timed_out;
    initial begin
        rx_valid  = 1'b0;
        rx_data   = 8'h00;
        rx_error  = 1'b0;
        tx_ready  = 1'b0;
        timed_out = 1'b0;
    end
    // idle line shows the inverse so a late sample never sees the byte
    task automatic send(input logic [7:0] b, input logic e);
        @(posedge core_clk);
        #1;
        rx_valid = 1'b1;
        rx_data  = b;
        rx_error = e;
        @(posedge core_clk);
        #1;
        rx_valid = 1'b0;
        rx_data  = ~b;
        rx_error = 1'b0;
    endtask : send
    task automatic take(input int stall);
        int n;
        n = 0;
        while (tx_valid !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        timed_out = (n >= 200);
        repeat (stall) @(posedge core_clk);
        #1;
        tx_ready = 1'b1;
        @(posedge core_clk);
        got = tx_data;
        #1;
        tx_ready = 1'b0;
    endtask : take
    task automatic seg(input logic [7:0] q[$], input int errat,
                       input logic [7:0] adj);
        logic [7:0] s;
        s = 8'h00;
        foreach (q[i]) begin
            s += q[i];
            send(q[i], i == errat);
        end
        send(8'h00 - s + adj, q.size() == errat);
    endtask : seg
endmodule : bsl_host_model

// File: bsl_loader.sv
`timescale 1ns/1ps
`include "bsl_consts.svh"
// Function
// - receive error in password segment: reply 18H, back to command wait
// - clocked synchronous mode: receive errors are never checked
// - password plus checksum must sum to 00H, else reply 11H
// - uniform non-FFH stored password or any mismatch: reply 11H
// - password segment clean: reply 10H
// - four address bytes, most significant first, form 32-bit start
// - two count bytes, high first, form 16-bit length
// - receive error in header segment: reply 18H, back to command wait
// - header sum nonzero: reply 11H and command wait, else 10H
// - data bytes written to consecutive RAM addresses from start
// - data block: 18H on error, 11H on bad sum, else 10H
// - after data ack, branch to received start address
// - 20H is flash sum, 30H is product info; echo the code
// - command receive error: previous upper nibble with low nibble 8H
// - unknown command: previous upper nibble with low nibble 1H
// - flash sum: 16-bit byte total, upper byte sent first
// - checksum of the two sum bytes follows them
// - byte after flash-sum checksum is a new command
// - 10H is RAM download; echo then verify password
// - twelve password bytes compared from lowest stored byte up
// - first byte 86H async or 30H sync, echoed back
module bsl_loader
    import bsl_pkg::*;
#(
    parameter logic [31:0] FLASH_BYTES = `BSL_FLASH_BYTES
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_error,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic [95:0] pw_bytes,
    output logic             ram_we,
    output logic [31:0]      ram_addr,
    output logic [7:0]       ram_wdata,
    output logic [31:0]      flash_addr,
    input  wire logic [7:0]  flash_rdata,
    output logic             jump_valid,
    output logic [31:0]      jump_addr,
    output logic             link_sync
);
    bsl_ctl_t    ctl_reg;
    bsl_ctl_t    ctl_next;
    logic [7:0]  acc_sum;
    logic [7:0]  sum_with;
    logic        acc_clr;
    logic        acc_add;
    logic        eff_err;
    logic        pw_uniform;
    logic [15:0] fsum;
    logic        fsum_done;
    logic [7:0]  sum_chk;

    // queue one reply byte; the send state returns to nxt once taken
    function automatic bsl_ctl_t reply(bsl_ctl_t c, logic [7:0] b,
                                       bsl_state_t nxt);
        bsl_ctl_t o;
        o          = c;
        o.tx_data  = b;
        o.tx_valid = 1'b1;
        o.after    = nxt;
        o.st       = BSL_SEND;
        return o;
    endfunction : reply

    // verdict for a checked segment, priority error > sum > password
    function automatic logic [7:0] verdict(logic err, logic [7:0] s,
                                           logic bad);
        logic [7:0] v;
        v = `BSL_ACK_OK;
        if (err) begin
            v = `BSL_ACK_RXERR;
        end else if (s != 8'h00) begin
            v = `BSL_ACK_BAD;
        end else if (bad) begin
            v = `BSL_ACK_BAD;
        end
        return v;
    endfunction : verdict

    // the receiver's error flag is meaningless when clocked by the far end
    assign eff_err = rx_error & ~ctl_reg.sync;

    assign sum_with = 8'(acc_sum + rx_data);
    assign acc_clr  = (ctl_reg.st == BSL_SEND);
    assign acc_add  = rx_valid && (ctl_reg.st == BSL_PW ||
                                   ctl_reg.st == BSL_HDR ||
                                   ctl_reg.st == BSL_DATA ||
                                   ctl_reg.st == BSL_DCHK);
    assign sum_chk  = 8'(8'h00 - 8'(fsum[15:8] + fsum[7:0]));

    bsl_sum8 u_seg_sum (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clr      (acc_clr),
        .add_en   (acc_add),
        .din      (rx_data),
        .sum      (acc_sum)
    );

    bsl_flash_sum #(
        .FLASH_BYTES (FLASH_BYTES)
    ) u_flash_sum (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .start       (ctl_reg.sum_start),
        .flash_rdata (flash_rdata),
        .flash_addr  (flash_addr),
        .sum         (fsum),
        .done        (fsum_done)
    );

    // an erased store (all FFH) is not a uniform-password lockout
    always_comb begin
        pw_uniform = (pw_bytes[7:0] != `BSL_PW_ERASED);
        for (int i = 1; i < `BSL_PW_BYTES; i++) begin
            if (pw_bytes[i*8 +: 8] != pw_bytes[7:0]) begin
                pw_uniform = 1'b0;
            end
        end
    end

    always_comb begin
        ctl_next            = ctl_reg;
        ctl_next.ram_we     = 1'b0;
        ctl_next.jump_valid = 1'b0;
        ctl_next.sum_start  = 1'b0;
        unique case (ctl_reg.st)
            BSL_MODE: begin
                if (rx_valid && rx_data == `BSL_MODE_ASYNC) begin
                    ctl_next.sync = 1'b0;
                    ctl_next = reply(ctl_next, rx_data, BSL_CMD);
                end else if (rx_valid && rx_data == `BSL_MODE_SYNC) begin
                    ctl_next.sync = 1'b1;
                    ctl_next = reply(ctl_next, rx_data, BSL_CMD);
                end
            end
            BSL_CMD: begin
                if (rx_valid) begin
                    if (eff_err) begin
                        ctl_next = reply(ctl_next,
                            {ctl_reg.prev_hi, `BSL_NIB_RXERR},
                            BSL_CMD);
                    end else if (rx_data == `BSL_CMD_RAM) begin
                        ctl_next.prev_hi = rx_data[7:4];
                        ctl_next = reply(ctl_next, rx_data, BSL_PW);
                    end else if (rx_data == `BSL_CMD_FSUM) begin
                        ctl_next.prev_hi   = rx_data[7:4];
                        ctl_next.sum_start = 1'b1;
                        ctl_next = reply(ctl_next, rx_data,
                                         BSL_SUMW);
                    end else if (rx_data == `BSL_CMD_INFO) begin
                        // payload of product information lives elsewhere
                        ctl_next.prev_hi = rx_data[7:4];
                        ctl_next = reply(ctl_next, rx_data,
                                         BSL_CMD);
                    end else begin
                        ctl_next = reply(ctl_next,
                            {ctl_reg.prev_hi, `BSL_NIB_BADCMD},
                            BSL_CMD);
                    end
                end
            end
            BSL_PW: begin
                if (rx_valid) begin
                    ctl_next.err = ctl_reg.err | eff_err;
                    ctl_next.cnt = ctl_reg.cnt + 4'h1;
                    if (ctl_reg.cnt != `BSL_PW_LAST) begin
                        if (rx_data != pw_bytes[ctl_reg.cnt*8 +: 8]) begin
                            ctl_next.pw_bad = 1'b1;
                        end
                    end else if (verdict(ctl_next.err, sum_with,
                                 ctl_reg.pw_bad | pw_uniform)
                                 == `BSL_ACK_OK) begin
                        ctl_next = reply(ctl_next, `BSL_ACK_OK,
                                         BSL_HDR);
                    end else begin
                        ctl_next = reply(ctl_next,
                            verdict(ctl_next.err, sum_with,
                                    ctl_reg.pw_bad | pw_uniform),
                            BSL_CMD);
                    end
                end
            end
            BSL_HDR: begin
                if (rx_valid) begin
                    ctl_next.err = ctl_reg.err | eff_err;
                    ctl_next.cnt = ctl_reg.cnt + 4'h1;
                    if (ctl_reg.cnt < `BSL_HDR_ADDR_END) begin
                        ctl_next.addr = {ctl_reg.addr[23:0], rx_data};
                    end else if (ctl_reg.cnt < `BSL_HDR_LAST) begin
                        ctl_next.len = {ctl_reg.len[7:0], rx_data};
                    end else if (verdict(ctl_next.err, sum_with, 1'b0)
                                 == `BSL_ACK_OK) begin
                        ctl_next.base = ctl_reg.addr;
                        ctl_next = reply(ctl_next, `BSL_ACK_OK,
                            (ctl_reg.len == 16'h0) ? BSL_DCHK
                                                   : BSL_DATA);
                    end else begin
                        ctl_next = reply(ctl_next,
                            verdict(ctl_next.err, sum_with, 1'b0),
                            BSL_CMD);
                    end
                end
            end
            BSL_DATA: begin
                if (rx_valid) begin
                    ctl_next.err       = ctl_reg.err | eff_err;
                    ctl_next.ram_we    = 1'b1;
                    ctl_next.ram_addr  = ctl_reg.addr;
                    ctl_next.ram_wdata = rx_data;
                    ctl_next.addr      = ctl_reg.addr + 32'h1;
                    ctl_next.len       = ctl_reg.len - 16'h1;
                    if (ctl_reg.len == 16'h1) begin
                        ctl_next.st = BSL_DCHK;
                    end
                end
            end
            BSL_DCHK: begin
                if (rx_valid) begin
                    ctl_next.err = ctl_reg.err | eff_err;
                    if (verdict(ctl_next.err, sum_with, 1'b0)
                        == `BSL_ACK_OK) begin
                        ctl_next = reply(ctl_next, `BSL_ACK_OK,
                                         BSL_JUMP);
                    end else begin
                        ctl_next = reply(ctl_next,
                            verdict(ctl_next.err, sum_with, 1'b0),
                            BSL_CMD);
                    end
                end
            end
            BSL_SUMW: begin
                if (fsum_done) begin
                    ctl_next = reply(ctl_next, fsum[15:8],
                                     BSL_SUMLO);
                end
            end
            BSL_SUMLO: begin
                ctl_next = reply(ctl_next, fsum[7:0], BSL_SUMCK);
            end
            BSL_SUMCK: begin
                ctl_next = reply(ctl_next, sum_chk, BSL_CMD);
            end
            BSL_SEND: begin
                // bytes arriving while a reply is pending are dropped
                if (tx_ready) begin
                    ctl_next.tx_valid = 1'b0;
                    ctl_next.st       = ctl_reg.after;
                    ctl_next.cnt      = 4'h0;
                    ctl_next.err      = 1'b0;
                    ctl_next.pw_bad   = 1'b0;
                end
            end
            BSL_JUMP: begin
                ctl_next.jump_valid = 1'b1;
                ctl_next.st         = BSL_DONE;
            end
            BSL_DONE: begin
                // control now belongs to the loaded code
                ctl_next.st = BSL_DONE;
            end
            default: begin
                ctl_next.st = BSL_MODE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_reg         <= '0;
            ctl_reg.st      <= BSL_MODE;
            ctl_reg.after   <= BSL_MODE;
            ctl_reg.prev_hi <= `BSL_PREV_HI_RST;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign tx_valid   = ctl_reg.tx_valid;
    assign tx_data    = ctl_reg.tx_data;
    assign ram_we     = ctl_reg.ram_we;
    assign ram_addr   = ctl_reg.ram_addr;
    assign ram_wdata  = ctl_reg.ram_wdata;
    assign jump_valid = ctl_reg.jump_valid;
    assign jump_addr  = ctl_reg.base;
    assign link_sync  = ctl_reg.sync;
endmodule : bsl_loader

// File: bsl_loader_asserts.sv
`timescale 1ns/1ps
`include "bsl_consts.svh"
module bsl_loader_chk
    import bsl_pkg::*;
#(
    parameter logic [31:0] FLASH_BYTES = `BSL_FLASH_BYTES
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_error,
    input wire logic        tx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic [95:0] pw_bytes,
    input wire logic        ram_we,
    input wire logic [31:0] ram_addr,
    input wire logic [7:0]  ram_wdata,
    input wire logic [31:0] flash_addr,
    input wire logic [7:0]  flash_rdata,
    input wire logic        jump_valid,
    input wire logic [31:0] jump_addr,
    input wire logic        link_sync
);
    logic        ok_reg;
    logic        wr_reg;
    logic [31:0] last_reg;
    logic [31:0] base_reg;
    logic        ack_ok;
    assign ack_ok = tx_valid && tx_ready && tx_data == 8'h10;
    // any reply ends a write run, so a retried download may restart
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ok_reg   <= 1'b0;
            wr_reg   <= 1'b0;
            last_reg <= 32'h0000_0000;
            base_reg <= 32'h0000_0000;
        end else if (ram_we) begin
            ok_reg   <= 1'b1;
            wr_reg   <= 1'b1;
            last_reg <= ram_addr;
            if (!ok_reg) begin
                base_reg <= ram_addr;
            end
        end else if (tx_valid && tx_ready) begin
            ok_reg <= 1'b0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    mode_sync_a: assert property ($rose(link_sync) |->
        $past(rx_valid) && $past(rx_data) == 8'h30 ||
        $past(rx_valid, 2) && $past(rx_data, 2) == 8'h30)
        else $error("sync mode without a 30 mode byte");
    sync_fixed_a: assert property (link_sync |=> link_sync)
        else $error("link mode changed after selection");
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data))
        else $error("reply dropped or changed before taken");
    ram_data_a: assert property (ram_we |->
        $past(rx_valid) && ram_wdata == $past(rx_data))
        else $error("ram write data is not the last byte");
    ram_step_a: assert property (ram_we && ok_reg |->
        ram_addr == last_reg + 32'h0000_0001)
        else $error("ram address not consecutive");
    jump_addr_a: assert property (jump_valid && wr_reg |->
        jump_addr == base_reg)
        else $error("branch target is not the load start");
    jump_ack_a: assert property (jump_valid |->
        $past(ack_ok) || $past(ack_ok, 2) || $past(ack_ok, 3))
        else $error("branch without a normal acknowledge");
    jump_idle_a: assert property (jump_valid |=>
        (!jump_valid && !ram_we && !tx_valid) [*8])
        else $error("activity after the branch");
endmodule : bsl_loader_chk

bind bsl_loader bsl_loader_chk #(.FLASH_BYTES(FLASH_BYTES)) u_chk (
    .core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_error(rx_error), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .pw_bytes(pw_bytes),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .jump_valid(jump_valid), .jump_addr(jump_addr),
    .link_sync(link_sync));

// File: bsl_pkg.sv
package bsl_pkg;

    typedef enum logic [3:0] {
        BSL_MODE,
        BSL_CMD,
        BSL_PW,
        BSL_HDR,
        BSL_DATA,
        BSL_DCHK,
        BSL_SUMW,
        BSL_SUMLO,
        BSL_SUMCK,
        BSL_SEND,
        BSL_JUMP,
        BSL_DONE
    } bsl_state_t;

    typedef struct packed {
        bsl_state_t  st;
        bsl_state_t  after;
        logic        sync;
        logic [3:0]  prev_hi;
        logic [3:0]  cnt;
        logic        err;
        logic        pw_bad;
        logic [31:0] addr;
        logic [31:0] base;
        logic [15:0] len;
        logic [7:0]  tx_data;
        logic        tx_valid;
        logic        ram_we;
        logic [31:0] ram_addr;
        logic [7:0]  ram_wdata;
        logic        jump_valid;
        logic        sum_start;
    } bsl_ctl_t;

    typedef struct packed {
        logic        run;
        logic        pend;
        logic        done;
        logic [31:0] addr;
        logic [15:0] sum;
    } bsl_fsum_t;

    typedef struct packed {
        logic [7:0] sum;
    } bsl_acc_t;

endpackage : bsl_pkg

// File: bsl_sum8.sv
`timescale 1ns/1ps
module bsl_sum8
    import bsl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clr,
    input  wire logic       add_en,
    input  wire logic [7:0] din,
    output logic [7:0]      sum
);
    bsl_acc_t acc_reg;
    bsl_acc_t acc_next;

    always_comb begin
        acc_next = acc_reg;
        if (clr) begin
            acc_next.sum = 8'h00;
        end else if (add_en) begin
            // carries dropped: modulo 256
            acc_next.sum = 8'(acc_reg.sum + din);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    assign sum = acc_reg.sum;
endmodule : bsl_sum8

// File: test_boot_serial_loader.sv
`timescale 1ns/1ps
module test_boot_serial_loader;
    import bsl_pkg::*;
    localparam logic [95:0] PW = 96'hB1A2_9384_7566_5748_3921_1A0B;
    logic        core_clk;
    logic        resetn;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_error;
    logic        tx_ready;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic [95:0] pw_val;
    logic        ram_we;
    logic [31:0] ram_addr;
    logic [7:0]  ram_wdata;
    logic [31:0] flash_addr;
    logic [7:0]  flash_rdata;
    logic        jump_valid;
    logic [31:0] jump_addr;
    logic        link_sync;
    logic [31:0] ja;
    logic [39:0] wq[$];
    logic [7:0]  pwq[$];
    logic [7:0]  hq[$];
    logic [7:0]  dq[$];
    logic [7:0]  q[$];
    int          jumps;
    int          n_errors;
    int          total_checks;
    bsl_loader #(.FLASH_BYTES(32'h0000_0010)) dut (
        .core_clk(core_clk), .resetn(resetn), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_error(rx_error), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .pw_bytes(pw_val),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .jump_valid(jump_valid), .jump_addr(jump_addr),
        .link_sync(link_sync));
    bsl_host_model m (
        .core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_error(rx_error), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data));
    function automatic logic [7:0] fb(input logic [31:0] a);
        return a[7:0] ^ 8'hC3;
    endfunction : fb
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial flash_rdata = 8'h00;
    always @(posedge core_clk) begin
        flash_rdata <= fb(flash_addr);
        if (ram_we === 1'b1) wq.push_back({ram_addr, ram_wdata});
        if (jump_valid === 1'b1) begin
            jumps++;
            ja = jump_addr;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk8
    task automatic chk32(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk32
    task automatic rep(input logic [7:0] e, input int st = 0);
        m.take(st);
        if (m.timed_out) begin
            n_errors++;
            tally_and_finish();
        end
        chk8(e, m.got);
    endtask : rep
    task automatic do_reset();
        resetn = 1'b0;
        jumps = 0;
        repeat (8) @(posedge core_clk);
        #1;
        resetn = 1'b1;
    endtask : do_reset
    task automatic open_dl();
        m.send(8'h10, 1'b0);
        rep(8'h10);
    endtask : open_dl
    task automatic wait_jump(input logic [31:0] a);
        for (int i = 0; i < 10 && jumps == 0; i++) @(posedge core_clk);
        chk8(8'h01, jumps[7:0]);
        chk32(a, ja);
    endtask : wait_jump
    task automatic t_mode();
        m.send(8'h55, 1'b0);
        m.send(8'h86, 1'b0);
        rep(8'h86);
        chk8(8'h00, {7'h00, link_sync});
        $display("mode test done");
    endtask : t_mode
    task automatic t_cmds();
        logic [15:0] fs;
        fs = 16'h0000;
        for (int i = 0; i < 16; i++) fs += {8'h00, fb(i)};
        m.send(8'h5A, 1'b0);
        rep(8'h01);
        m.send(8'h20, 1'b1);
        rep(8'h08);
        m.send(8'h20, 1'b0);
        rep(8'h20, 30);
        rep(fs[15:8], 2);
        rep(fs[7:0]);
        rep(8'h00 - fs[15:8] - fs[7:0]);
        m.send(8'h30, 1'b0);
        rep(8'h30);
        m.send(8'hC4, 1'b0);
        rep(8'h31);
        m.send(8'h10, 1'b1);
        rep(8'h38);
        $display("command test done");
    endtask : t_cmds
    task automatic t_pw();
        open_dl();
        m.seg(pwq, 4, 8'h00);
        rep(8'h18);
        open_dl();
        m.seg(pwq, 99, 8'h01);
        rep(8'h11);
        q = pwq;
        q[11] ^= 8'h01;
        open_dl();
        m.seg(q, 99, 8'h00);
        rep(8'h11);
        pw_val = {12{8'h33}};
        q = '{12{8'h33}};
        open_dl();
        m.seg(q, 99, 8'h00);
        rep(8'h11);
        $display("password test done");
    endtask : t_pw
    task automatic t_hdr();
        pw_val = {12{8'hFF}};
        q = '{12{8'hFF}};
        open_dl();
        m.seg(q, 99, 8'h00);
        rep(8'h10);
        m.seg(hq, 2, 8'h00);
        rep(8'h18);
        pw_val = PW;
        open_dl();
        m.seg(pwq, 99, 8'h00);
        rep(8'h10);
        m.seg(hq, 99, 8'h80);
        rep(8'h11);
        $display("header test done");
    endtask : t_hdr
    task automatic t_load(input logic [7:0] adj, input int errat,
                          input logic [7:0] e);
        wq.delete();
        open_dl();
        m.seg(pwq, 99, 8'h00);
        rep(8'h10);
        m.seg(hq, 99, 8'h00);
        rep(8'h10, 3);
        m.seg(dq, errat, adj);
        rep(e);
        $display("load test done");
    endtask : t_load
    task automatic t_ram();
        chk8(8'h05, wq.size());
        foreach (wq[i]) begin
            chk32(32'h2000_0400 + i, wq[i][39:8]);
            chk8(dq[i], wq[i][7:0]);
        end
        wait_jump(32'h2000_0400);
        $display("ram test done");
    endtask : t_ram
    task automatic t_sync();
        do_reset();
        m.send(8'h30, 1'b0);
        rep(8'h30);
        chk8(8'h01, {7'h00, link_sync});
        m.send(8'h10, 1'b1);
        rep(8'h10);
        m.seg(pwq, 0, 8'h00);
        rep(8'h10);
        q = '{8'h20, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
        m.seg(q, 6, 8'h00);
        rep(8'h10);
        q.delete();
        m.seg(q, 0, 8'h00);
        rep(8'h10);
        wait_jump(32'h2000_0700);
        $display("sync test done");
    endtask : t_sync
    initial begin
        n_errors = 0;
        total_checks = 0;
        pw_val = PW;
        for (int i = 0; i < 12; i++) pwq.push_back(PW[8*i+:8]);
        hq = '{8'h20, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05};
        dq = '{8'h9C, 8'h01, 8'hFF, 8'h40, 8'h3E};
        do_reset();
        t_mode();
        t_cmds();
        t_pw();
        t_hdr();
        t_load(8'h01, 99, 8'h11);
        t_load(8'h00, 2, 8'h18);
        t_load(8'h00, 99, 8'h10);
        t_ram();
        t_sync();
        tally_and_finish();
    end
endmodule : test_boot_serial_loader
